// ---- rtl/fav_fifo_autovector.sv ----
`timescale 1ns/1ns
// How it works
// - fourteen shared sources, each fixed priority one to fourteen with own vector
// - endpoint 2/4/6/8 level flags: priorities 1-4, vectors 80,84,88,8C
// - endpoint 2/4/6/8 empty flags: priorities 5-8, vectors 90,94,98,9C
// - endpoint 2/4/6/8 full flags: priorities 9-12, vectors A0,A4,A8,AC
// - waveform done priority 13 vector B0, waveform event priority 14 vector B4
// - autovector on: byte fetched at 0055 becomes vector code of highest priority pending source
// - jump target is page byte at 0054 high, vector code low
// - taking interrupt, core pushes pc and fetches jump at 0053
// - writing power control bit 0 enters power-down, oscillator and pll stop
// - wakeup restarts oscillator, waits pll stable, then wakeup interrupt
// - wakeup sequence identical whether or not attached to serial bus
// - wake on serial bus activity, primary pin, or secondary pin
// - secondary wakeup pin can instead serve as general purpose io
// - primary wakeup pin active low after reset unless polarity changed
module fav_fifo_autovector
  import fav_pkg::*;
#(
  parameter int SETTLE_CYC = FAV_PLL_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [FAV_NUM_SRC-1:0] src_event,
  input wire logic [FAV_NUM_SRC-1:0] src_clear,
  input wire logic fifo_autovector_enable,
  input wire fav_fetch_req_t fetch_req,
  output fav_fetch_rsp_t fetch_rsp,
  output logic fifo_shared_interrupt,
  output logic [FAV_NUM_SRC-1:0] src_pending,
  input wire logic pwr_ctrl_wr,
  input wire logic [7:0] processor_power_control,
  input wire logic bus_activity,
  input wire logic wakeup_pin,
  input wire logic wakeup_polarity,
  input wire logic port_a3_secondary_wakeup,
  input wire logic secondary_wakeup_is_gpio,
  output logic osc_run,
  output logic pll_run,
  output logic powered_down,
  output logic wakeup_irq
);

  logic [FAV_NUM_SRC-1:0] pend_reg;
  logic [FAV_NUM_SRC-1:0] pend_next;
  logic [3:0] top_idx;
  logic any_pend;
  logic [7:0] top_vec;
  logic vec_fetch;
  logic [7:0] rsp_data;
  fav_fetch_rsp_t rsp_reg;

  fav_pwr_state_t pwr_reg;
  fav_pwr_state_t pwr_next;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_reg;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_next;
  logic wake_pri;
  logic wake_sec;
  logic wake_any;
  logic pd_req;
  logic wake_irq_reg;
  logic irq_reg;

  // set wins over clear so no event is lost
  assign pend_next = (pend_reg & ~src_clear) | src_event;

  // lowest index wins: index order is the priority order
  always_comb begin
    top_idx = 4'(FAV_NUM_SRC - 1);
    for (int i = FAV_NUM_SRC - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        top_idx = 4'(i);
      end
    end
  end

  assign any_pend = |pend_reg;
  // codes step by four from 80: 80..8C level, 90..9C empty, A0..AC full, B0, B4
  assign top_vec = FAV_VEC_BASE + 8'({4'h0, top_idx} * FAV_VEC_STEP);

  // only the low byte of the jump is touched; 0053 and 0054 pass through
  assign vec_fetch = fetch_req.rd && fetch_req.addr == FAV_VEC_ADDR;
  assign rsp_data = (vec_fetch && fifo_autovector_enable && any_pend) ? top_vec
                  : fetch_req.mem_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_reg <= '0;
      irq_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      pend_reg <= pend_next;
      irq_reg <= |pend_next;
      rsp_reg.valid <= fetch_req.rd;
      rsp_reg.data <= rsp_data;
    end
  end

  assign fetch_rsp = rsp_reg;
  assign src_pending = pend_reg;
  assign fifo_shared_interrupt = irq_reg;

  // polarity input low means active low, the reset default
  assign wake_pri = wakeup_pin ^ ~wakeup_polarity;
  // gpio use gates the pin off; an rc timer needs the pin left in wake mode
  assign wake_sec = ~secondary_wakeup_is_gpio & port_a3_secondary_wakeup;
  // no attachment input: the sequence cannot depend on it
  assign wake_any = bus_activity | wake_pri | wake_sec;
  assign pd_req = pwr_ctrl_wr & processor_power_control[0];

  always_comb begin
    pwr_next = pwr_reg;
    settle_next = settle_reg;
    unique case (pwr_reg)
      FAV_RUN: begin
        if (pd_req) begin
          pwr_next = FAV_DOWN;
        end
      end
      FAV_DOWN: begin
        if (wake_any) begin
          pwr_next = FAV_SETTLE;
          settle_next = '0;
        end
      end
      FAV_SETTLE: begin
        if (settle_reg == ($bits(settle_reg))'(SETTLE_CYC - 1)) begin
          pwr_next = FAV_RUN;
        end else begin
          settle_next = settle_reg + 1'b1;
        end
      end
      default: pwr_next = FAV_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_reg <= FAV_RUN;
      settle_reg <= '0;
      wake_irq_reg <= 1'b0;
      osc_run <= 1'b1;
      pll_run <= 1'b1;
      powered_down <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      settle_reg <= settle_next;
      wake_irq_reg <= (pwr_reg == FAV_SETTLE) && (pwr_next == FAV_RUN);
      osc_run <= pwr_next != FAV_DOWN;
      pll_run <= pwr_next != FAV_DOWN;
      powered_down <= pwr_next != FAV_RUN;
    end
  end

  assign wakeup_irq = wake_irq_reg;

  vec_value_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && fetch_req.addr == FAV_VEC_ADDR && fifo_autovector_enable && pend_reg[0]
    |=> fetch_rsp.data == 8'h80)
    else $error("top source vector not substituted");

  last_vec_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && fetch_req.addr == FAV_VEC_ADDR && fifo_autovector_enable && pend_reg == 14'h2000
    |=> fetch_rsp.data == 8'hB4)
    else $error("lowest source vector wrong");

  full_vec_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && fetch_req.addr == FAV_VEC_ADDR && fifo_autovector_enable && pend_reg == 14'h0100
    |=> fetch_rsp.data == 8'hA0)
    else $error("full flag vector wrong");

  vec_off_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && !fifo_autovector_enable |=> fetch_rsp.data == $past(fetch_req.mem_data))
    else $error("stored byte altered while autovector off");

  pend_hold_a: assert property (@(posedge clk) disable iff (rst)
    pend_reg[3] && !src_clear[3] |=> pend_reg[3])
    else $error("pending source lost without clear");

  pwr_down_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_RUN && pd_req |=> !osc_run && !pll_run)
    else $error("power-down did not stop clocks");

  wake_wait_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pll_run) |-> !wakeup_irq ##1 !wakeup_irq)
    else $error("wakeup interrupt before pll settled");

  wake_pin_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN && !wakeup_polarity && !wakeup_pin |=> pwr_reg == FAV_SETTLE)
    else $error("active low wakeup ignored");

  // expected codes written out, independent of the base-plus-step adder above
  localparam logic [7:0] VEC_TAB [FAV_NUM_SRC] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98,
    8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4};

  for (genvar g = 0; g < FAV_NUM_SRC; g++) begin : g_src_chk
    src_hold_a: assert property (@(posedge clk) disable iff (rst)
      pend_reg[g] && !src_clear[g] |=> pend_reg[g])
      else $error("pending source dropped without clear");

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
      src_event[g] |=> pend_reg[g])
      else $error("source event not latched");

    clr_done_a: assert property (@(posedge clk) disable iff (rst)
      src_clear[g] && !src_event[g] |=> !pend_reg[g])
      else $error("cleared source still pending");

    src_vec_a: assert property (@(posedge clk) disable iff (rst)
      fetch_req.rd && fetch_req.addr == FAV_VEC_ADDR && fifo_autovector_enable && pend_reg[g]
      && ((pend_reg & ((14'h1 << g) - 14'h1)) == 14'h0) |=> fetch_rsp.data == VEC_TAB[g])
      else $error("vector does not match source priority");
  end

  page_pass_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && fetch_req.addr == FAV_PAGE_ADDR |=> fetch_rsp.data == $past(fetch_req.mem_data))
    else $error("page byte altered");

  jmp_pass_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && fetch_req.addr == FAV_JMP_ADDR |=> fetch_rsp.data == $past(fetch_req.mem_data))
    else $error("jump opcode altered");

  idle_pass_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd && fetch_req.addr == FAV_VEC_ADDR && pend_reg == 14'h0
    |=> fetch_rsp.data == $past(fetch_req.mem_data))
    else $error("vector substituted with nothing pending");

  rsp_valid_a: assert property (@(posedge clk) disable iff (rst)
    fetch_req.rd |=> fetch_rsp.valid)
    else $error("fetch answer missing");

  rsp_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !fetch_req.rd |=> !fetch_rsp.valid)
    else $error("fetch answer without request");

  irq_line_a: assert property (@(posedge clk) disable iff (rst)
    fifo_shared_interrupt == (|src_pending))
    else $error("shared interrupt disagrees with pending bits");

  wake_ok_a: assert property (@(posedge clk) disable iff (rst)
    wakeup_irq |-> osc_run && pll_run && !powered_down)
    else $error("wakeup interrupt while clocks not running");

  wake_pulse_a: assert property (@(posedge clk) disable iff (rst)
    wakeup_irq |=> !wakeup_irq)
    else $error("wakeup interrupt longer than one cycle");

  down_hold_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN && !wake_any |=> pwr_reg == FAV_DOWN && !osc_run)
    else $error("power-down left without wakeup");

  sec_gpio_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN && secondary_wakeup_is_gpio && !bus_activity && !wake_pri |=> pwr_reg == FAV_DOWN)
    else $error("gpio configured pin caused wakeup");

  bus_wake_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN && bus_activity |=> pwr_reg == FAV_SETTLE && osc_run && pll_run)
    else $error("bus activity did not wake");

  sec_wake_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN && port_a3_secondary_wakeup && !secondary_wakeup_is_gpio |=> pwr_reg == FAV_SETTLE)
    else $error("secondary pin did not wake");

  pol_high_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN && wakeup_polarity && wakeup_pin |=> pwr_reg == FAV_SETTLE)
    else $error("active high wakeup ignored");

  settle_keep_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_SETTLE |=> pwr_reg != FAV_DOWN)
    else $error("power write accepted while settling");

  osc_pll_a: assert property (@(posedge clk) disable iff (rst)
    osc_run == pll_run)
    else $error("oscillator and pll run flags differ");

  run_state_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_RUN |-> osc_run && !powered_down)
    else $error("running with clocks stopped");

  down_state_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_DOWN |-> !osc_run && !pll_run && powered_down)
    else $error("clocks running in power-down");

  settle_state_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_SETTLE |-> osc_run && pll_run && powered_down)
    else $error("settle state outputs wrong");

  wr_zero_a: assert property (@(posedge clk) disable iff (rst)
    pwr_reg == FAV_RUN && pwr_ctrl_wr && !processor_power_control[0] |=> pwr_reg == FAV_RUN)
    else $error("power-down entered with bit 0 clear");

endmodule // fav_fifo_autovector

// ---- include/fav_pkg.sv ----
package fav_pkg;

  localparam int FAV_NUM_SRC = 14;
  localparam int FAV_ADDR_W = 16;

  // jump-table fetch addresses seen by the processor
  localparam logic [15:0] FAV_JMP_ADDR = 16'h0053;
  localparam logic [15:0] FAV_PAGE_ADDR = 16'h0054;
  localparam logic [15:0] FAV_VEC_ADDR = 16'h0055;

  // vector codes, index 0 is priority 1
  localparam logic [7:0] FAV_VEC_BASE = 8'h80;
  localparam logic [7:0] FAV_VEC_STEP = 8'h04;

  // source index positions
  localparam int FAV_SRC_LEVEL = 0;
  localparam int FAV_SRC_EMPTY = 4;
  localparam int FAV_SRC_FULL = 8;
  localparam int FAV_SRC_WDONE = 12;
  localparam int FAV_SRC_WFORM = 13;

  localparam logic FAV_PWRDN_BIT_RST = 1'b0;
  localparam logic FAV_WAKE_POL_RST = 1'b0;

  // oscillator / pll settle time before the wakeup interrupt
  localparam int FAV_PLL_SETTLE_NS = 2000;
  localparam int FAV_CLK_NS = 10;
  localparam int FAV_PLL_SETTLE_CYC = (FAV_PLL_SETTLE_NS + FAV_CLK_NS - 1) / FAV_CLK_NS;

  typedef enum logic [1:0] {
    FAV_RUN,
    FAV_DOWN,
    FAV_SETTLE
  } fav_pwr_state_t;

  // processor code-fetch request and answer
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
    logic [7:0] mem_data;
  } fav_fetch_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fav_fetch_rsp_t;

endpackage

// ---- tb/fav_cpu_model.sv ----
`timescale 1ns/1ns
module fav_cpu_model
  import fav_pkg::*;
#(
  parameter logic [7:0] STORED = 8'h3C
) (
  input wire logic clk,
  input wire logic take,
  input wire logic [7:0] page,
  input wire fav_fetch_rsp_t fetch_rsp,
  output fav_fetch_req_t fetch_req,
  output logic [15:0] jump_target,
  output logic done
);
  logic [7:0] got [3];
  initial begin
    fetch_req = '0;
    jump_target = '0;
    done = 1'b0;
    forever begin
      @(posedge clk);
      if (take) begin
        done = 1'b0;
        for (int i = 0; i < 3; i++) begin
          #1 fetch_req = '{1'b1, FAV_JMP_ADDR + 16'(i), (i == 0) ? 8'h02 : (i == 1) ? page : STORED};
          @(posedge clk);
          #1 fetch_req.rd = 1'b0;
          // released memory byte flips so a stale value never matches
          fetch_req.mem_data = ~fetch_req.mem_data;
          // answer stands from this edge to the next one
          got[i] = fetch_rsp.valid ? fetch_rsp.data : 8'hXX;
          @(posedge clk);
        end
        jump_target = {got[1], got[2]};
        done = 1'b1;
      end
    end
  end
endmodule // fav_cpu_model

// ---- tb/fav_fifo_autovector_tb.sv ----
`timescale 1ns/1ns
module fav_fifo_autovector_tb
  import fav_pkg::*;
;
  localparam logic [7:0] PAGE = 8'h5A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] src_event = '0;
  logic [13:0] src_clear = '0;
  logic av_en = 1'b1;
  logic pwr_wr = 1'b0;
  logic bus_act = 1'b0;
  logic wake_pin = 1'b1;
  logic sec_wake = 1'b0;
  logic sec_gpio = 1'b0;
  logic wake_pol = 1'b0;
  logic [7:0] pwr_val = 8'h01;
  logic take = 1'b0;
  fav_fetch_req_t fetch_req;
  fav_fetch_rsp_t fetch_rsp;
  logic [13:0] src_pending;
  logic irq_line, osc_run, pll_run, powered_down, wakeup_irq, done;
  logic [15:0] jump_target;
  int miscompares = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  fav_fifo_autovector #(.SETTLE_CYC(4)) dut (.clk(clk), .rst(rst), .src_event(src_event),
    .src_clear(src_clear), .fifo_autovector_enable(av_en), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
    .fifo_shared_interrupt(irq_line), .src_pending(src_pending), .pwr_ctrl_wr(pwr_wr),
    .processor_power_control(pwr_val), .bus_activity(bus_act), .wakeup_pin(wake_pin),
    .wakeup_polarity(wake_pol), .port_a3_secondary_wakeup(sec_wake), .secondary_wakeup_is_gpio(sec_gpio),
    .osc_run(osc_run), .pll_run(pll_run), .powered_down(powered_down), .wakeup_irq(wakeup_irq));
  fav_cpu_model cpu (.clk(clk), .take(take), .page(PAGE), .fetch_rsp(fetch_rsp), .fetch_req(fetch_req),
    .jump_target(jump_target), .done(done));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic give_up(input int n);
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic vector_fetch(input logic [7:0] exp);
    int n;
    take = 1'b1;
    tick(1);
    take = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    give_up(n);
    check(jump_target, {PAGE, exp});
  endtask
  initial begin
    int n;
    tick(8);
    rst = 1'b0;
    src_event = '1;
    tick(1);
    src_event = '0;
    tick(1);
    check(16'(src_pending), 16'h3FFF);
    for (int i = 0; i < 14; i++) begin
      vector_fetch(8'h80 + 8'(4 * i));
      src_clear[i] = 1'b1;
      tick(1);
      src_clear = '0;
    end
    tick(1);
    check(16'(irq_line), 16'h0000);
    vector_fetch(8'h3C);
    src_event[13] = 1'b1;
    tick(1);
    src_event = '0;
    av_en = 1'b0;
    vector_fetch(8'h3C);
    check(16'(irq_line), 16'h0001);
    $display("test vectors done");
    pwr_val = 8'hFE;
    pwr_wr = 1'b1;
    tick(1);
    pwr_wr = 1'b0;
    pwr_val = 8'h01;
    tick(1);
    check(16'(powered_down), 16'h0000);
    for (int k = 0; k < 5; k++) begin
      pwr_wr = 1'b1;
      tick(1);
      pwr_wr = 1'b0;
      tick(1);
      check({13'h0, powered_down, osc_run, pll_run}, 16'h0004);
      if (k == 3) begin
        sec_gpio = 1'b1;
        sec_wake = 1'b1;
        tick(10);
        check(16'(powered_down), 16'h0001);
        sec_gpio = 1'b0;
      end
      bus_act = (k == 0);
      wake_pin = (k != 1);
      wake_pol = (k == 4);
      sec_wake = (k == 2) || (k == 3);
      n = 0;
      while (wakeup_irq !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      give_up(n);
      check({13'h0, powered_down, osc_run, pll_run}, 16'h0003);
      bus_act = 1'b0;
      wake_pin = 1'b1;
      wake_pol = 1'b0;
      sec_wake = 1'b0;
      tick(2);
    end
    $display("test power done");
    report_and_stop();
  end
endmodule // fav_fifo_autovector_tb
